// file: logic/lsm_band.sv
// upper limit of the setpoint band from setpoint and relative hysteresis
`timescale 1ns/1ps
`default_nettype none
module lsm_band
    import lsm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // setpoint and hysteresis percent
    input wire logic [15:0] setpoint,
    input wire logic [7:0] hyst_pct,
    // band upper limit
    output logic [15:0] upper
);
    typedef struct packed
    {
        logic [15:0] upper;
    } lsm_band_state_type;

    lsm_band_state_type state;
    lsm_band_state_type next_state;

    always_comb
    begin
        logic [31:0] prod;
        logic [31:0] up;
        prod = 32'(setpoint) * 32'(hyst_pct);
        up = 32'(setpoint) + prod / 32'd100;
        next_state.upper = (up > 32'h0000_ffff) ? 16'hffff : up[15:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign upper = state.upper;
endmodule
`default_nettype wire

// file: logic/lsm_offset_channel.sv
// fixed offset derivation of one secondary channel from the primary output
`timescale 1ns/1ps
`default_nettype none
module lsm_offset_channel
    import lsm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // primary output and configuration
    input wire logic [7:0] primary,
    input wire logic signed [8:0] offset,
    input wire logic [7:0] onoff_hyst,
    input wire logic enable,
    // derived value
    output logic [7:0] value
);
    typedef struct packed
    {
        logic on;
        logic [7:0] value;
    } lsm_oc_state_type;

    lsm_oc_state_type state;
    lsm_oc_state_type next_state;

    always_comb
    begin
        logic signed [10:0] sum;
        logic [8:0] thresh;
        logic [8:0] hyst;
        sum = 11'sd0;
        thresh = 9'h000;
        hyst = 9'h000;
        next_state = state;
        // negative offset: turn on only once primary clears threshold plus hysteresis;
        // a positive offset cannot toggle near zero, so it follows every output from 1
        thresh = (offset < 0) ? 9'(-offset) : 9'h000;
        hyst = (offset < 0) ? {1'b0, onoff_hyst} : 9'h000;
        if (primary == 8'h00 || !enable)
        begin
            next_state.on = 1'b0;
        end
        else if (!state.on && {1'b0, primary} > thresh + hyst)
        begin
            next_state.on = 1'b1;
        end
        else if (state.on && {1'b0, primary} <= thresh)
        begin
            next_state.on = 1'b0;
        end
        sum = $signed({3'b000, primary}) + 11'(offset);
        if (!next_state.on)
        begin
            next_state.value = 8'h00;
        end
        else if (sum < 0)
        begin
            next_state.value = 8'h00;
        end
        else if (sum > 11'sd255)
        begin
            next_state.value = 8'hff;
        end
        else
        begin
            next_state.value = sum[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign value = state.value;
endmodule
`default_nettype wire

// file: logic/lsm_pkg.sv
// package of constants, types and register map for the light setpoint manager
package lsm_pkg;
    localparam int unsigned clk_hz = 100_000_000;
    localparam int unsigned settle_ms = 2000;
    localparam int unsigned shift_timeout_ms = 30000;
    localparam int unsigned settle_cycles = (clk_hz / 1000) * settle_ms;
    localparam int unsigned shift_timeout_cycles = (clk_hz / 1000) * shift_timeout_ms;
    localparam int unsigned ms_cycles = clk_hz / 1000;

    localparam logic [7:0] reg_cfg = 8'h00;
    localparam logic [7:0] reg_default_sp = 8'h04;
    localparam logic [7:0] reg_limits = 8'h08;
    localparam logic [7:0] reg_offsets = 8'h0c;
    localparam logic [7:0] reg_status = 8'h10;
    localparam logic [7:0] reg_setpoint = 8'h14;

    localparam int unsigned cfg_persist_bit = 0;
    localparam int unsigned cfg_teach_pol_lsb = 1;
    localparam int unsigned cfg_overwrite_bit = 3;
    localparam int unsigned cfg_nchan_lsb = 4;
    localparam int unsigned cfg_method_lsb = 6;
    localparam int unsigned cfg_hyst_pct_lsb = 8;
    localparam int unsigned cfg_onoff_hyst_lsb = 16;

    localparam logic [31:0] cfg_reset = 32'h0000_1410;
    localparam logic [15:0] default_sp_reset = 16'h0190;
    localparam logic [31:0] limits_reset = 32'hffff_0000;
    localparam logic [31:0] offsets_reset = 32'h0000_0000;

    localparam logic [3:0] dim_stop = 4'h0;

    typedef enum logic [1:0]
    {
        teach_one_active = 2'b00,
        teach_zero_active = 2'b01,
        teach_both_active = 2'b10
    } lsm_teach_mode_type;

    typedef enum logic [1:0]
    {
        sh_idle = 2'b00,
        sh_active = 2'b01,
        sh_settle = 2'b10
    } lsm_shift_state_type;

    typedef struct packed
    {
        logic valid;
        logic [3:0] code;
    } lsm_dim_type;
endpackage

// file: logic/lsm_top.sv
// light setpoint manager: setpoint shift, teach, reset, download and channel offsets
// Behaviour
// - shift starts on 4-bit dimming in control
// - forward shift dimming to primary channel
// - sender stops shift; stop forwarded to primary
// - two seconds after stop, store measured brightness
// - thirty second timeout sends stop, then stores
// - limit crossed: stop, adopt limit as setpoint
// - option: shift temporary or permanent
// - permanent setpoint kept until new preset
// - teach stores measured brightness immediately
// - teach polarity configurable; inactive restores default
// - teach and reset ignore control state
// - reset input always restores default setpoint
// - download overwrites external setpoint only if enabled
// - without external preset, default setpoint used
// - one to three channels selectable
// - several channels: absolute byte outputs only
// - secondary channels derived from primary by offset
// - fixed offset above zero, zero forces zero
// - on-off hysteresis against secondary toggling
// - band upper limit recomputed from setpoint
// - two-byte external setpoint preset accepted
`timescale 1ns/1ps
`default_nettype none
module lsm_top
    import lsm_pkg::*;
#(
    parameter int unsigned settle_count = settle_cycles,
    parameter int unsigned timeout_count = shift_timeout_cycles
)
(
    // bus clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // control context and sensor
    input wire logic in_control,
    input wire logic phase_end,
    input wire logic [15:0] brightness,
    input wire logic config_download,
    // telegram objects in
    input wire lsm_dim_type shift_dim,
    input wire logic teach_valid,
    input wire logic teach_value,
    input wire logic sp_reset_valid,
    input wire logic preset_valid,
    input wire logic [15:0] preset_value,
    input wire logic [7:0] primary_abs,
    // telegram objects out
    output lsm_dim_type ch1_dim,
    output logic [15:0] active_setpoint,
    output logic [15:0] band_upper,
    output logic [7:0] ch1_abs,
    output logic [7:0] ch2_abs,
    output logic [7:0] ch3_abs,
    output logic shift_busy
);
    typedef struct packed
    {
        logic [31:0] cfg;
        logic [15:0] default_sp;
        logic [31:0] limits;
        logic [31:0] offsets;
        logic [15:0] setpoint;
        logic [15:0] perm_sp;
        logic external;
        logic temp_shift;
        lsm_shift_state_type sh;
        logic busy;
        logic [31:0] timer;
        logic limit_hit;
        logic [15:0] limit_val;
        lsm_dim_type ch1_dim;
        logic [7:0] ch1_abs;
        logic [7:0] ch2_abs;
        logic [7:0] ch3_abs;
        logic dp_pending;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
    } lsm_state_type;

    lsm_state_type state;
    lsm_state_type next_state;
    logic [7:0] sec2;
    logic [7:0] sec3;
    logic [15:0] upper;

    function automatic logic teach_active(input logic [1:0] mode, input logic v);
        case (mode)
            teach_one_active: teach_active = v;
            teach_zero_active: teach_active = !v;
            teach_both_active: teach_active = 1'b1;
            default: teach_active = v;
        endcase
    endfunction

    function automatic logic [31:0] reg_read(input lsm_state_type s, input logic [7:0] a);
        case (a)
            reg_cfg: reg_read = s.cfg;
            reg_default_sp: reg_read = {16'h0000, s.default_sp};
            reg_limits: reg_read = s.limits;
            reg_offsets: reg_read = s.offsets;
            reg_status: reg_read = {26'h0, s.limit_hit, s.temp_shift, s.external, 1'b0, s.sh};
            reg_setpoint: reg_read = {16'h0000, s.setpoint};
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction

    always_comb
    begin
        logic [1:0] nchan;
        logic [15:0] lo_lim;
        logic [15:0] hi_lim;
        logic new_preset;
        nchan = state.cfg[cfg_nchan_lsb +: 2];
        lo_lim = state.limits[15:0];
        hi_lim = state.limits[31:16];
        new_preset = 1'b0;
        next_state = state;
        next_state.ch1_dim = '0;

        // bus slave: zero wait state, whole-register writes
        next_state.dp_pending = hsel && hready && htrans[1];
        next_state.dp_write = hwrite;
        next_state.dp_addr = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            next_state.hrdata = reg_read(state, haddr[7:0]);
        end
        if (state.dp_pending && state.dp_write)
        begin
            case (state.dp_addr)
                reg_cfg: next_state.cfg = hwdata;
                reg_default_sp: next_state.default_sp = hwdata[15:0];
                reg_limits: next_state.limits = hwdata;
                reg_offsets: next_state.offsets = hwdata;
                default: next_state.cfg = state.cfg;
            endcase
        end

        // setpoint shift sequence
        case (state.sh)
            sh_idle:
            begin
                if (shift_dim.valid && in_control && shift_dim.code[2:0] != 3'b000)
                begin
                    next_state.ch1_dim = shift_dim;
                    next_state.sh = sh_active;
                    next_state.timer = 32'h0;
                    next_state.limit_hit = 1'b0;
                end
            end
            sh_active:
            begin
                next_state.timer = state.timer + 32'h1;
                if (shift_dim.valid)
                begin
                    next_state.ch1_dim = shift_dim;
                    next_state.timer = 32'h0;
                    if (shift_dim.code[2:0] == 3'b000)
                    begin
                        next_state.sh = sh_settle;
                    end
                end
                else if (brightness > hi_lim || brightness < lo_lim)
                begin
                    next_state.ch1_dim = '{valid: 1'b1, code: dim_stop};
                    next_state.limit_hit = 1'b1;
                    next_state.limit_val = (brightness > hi_lim) ? hi_lim : lo_lim;
                    next_state.setpoint = next_state.limit_val;
                    next_state.sh = sh_idle;
                    new_preset = 1'b1;
                end
                else if (state.timer >= 32'(timeout_count - 1))
                begin
                    next_state.ch1_dim = '{valid: 1'b1, code: dim_stop};
                    next_state.sh = sh_settle;
                    next_state.timer = 32'h0;
                end
            end
            sh_settle:
            begin
                next_state.timer = state.timer + 32'h1;
                if (state.timer >= 32'(settle_count - 1))
                begin
                    next_state.setpoint = brightness;
                    next_state.sh = sh_idle;
                    new_preset = 1'b1;
                end
            end
            default: next_state.sh = sh_idle;
        endcase
        if (new_preset)
        begin
            next_state.external = 1'b1;
            next_state.temp_shift = !state.cfg[cfg_persist_bit];
        end

        // temporary shift ends with the control phase
        if (phase_end && state.temp_shift)
        begin
            next_state.setpoint = state.perm_sp;
            next_state.temp_shift = 1'b0;
        end

        // preset, teach and reset act in any control state
        if (preset_valid)
        begin
            next_state.setpoint = preset_value;
            next_state.external = 1'b1;
            next_state.temp_shift = 1'b0;
        end
        if (teach_valid)
        begin
            if (teach_active(state.cfg[cfg_teach_pol_lsb +: 2], teach_value))
            begin
                next_state.setpoint = brightness;
                next_state.external = 1'b1;
                next_state.temp_shift = 1'b0;
            end
            else
            begin
                next_state.setpoint = state.default_sp;
                next_state.external = 1'b0;
                next_state.temp_shift = 1'b0;
            end
        end
        if (sp_reset_valid)
        begin
            next_state.setpoint = state.default_sp;
            next_state.external = 1'b0;
            next_state.temp_shift = 1'b0;
        end
        if (config_download && (state.cfg[cfg_overwrite_bit] || !state.external))
        begin
            next_state.setpoint = state.default_sp;
            next_state.external = 1'b0;
            next_state.temp_shift = 1'b0;
        end
        // permanent copy survives a temporary shift
        if (!next_state.temp_shift)
        begin
            next_state.perm_sp = next_state.setpoint;
        end

        next_state.busy = next_state.sh != sh_idle;
        // channel outputs: secondaries only when configured
        next_state.ch1_abs = primary_abs;
        next_state.ch2_abs = (nchan >= 2'd2) ? sec2 : 8'h00;
        next_state.ch3_abs = (nchan >= 2'd3) ? sec3 : 8'h00;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= '0;
            state.cfg <= cfg_reset;
            state.default_sp <= default_sp_reset;
            state.setpoint <= default_sp_reset;
            state.perm_sp <= default_sp_reset;
            state.limits <= limits_reset;
            state.offsets <= offsets_reset;
        end
        else
        begin
            state <= next_state;
        end
    end

    lsm_offset_channel u_ch2
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .primary(primary_abs),
        .offset(state.offsets[8:0]),
        .onoff_hyst(state.cfg[cfg_onoff_hyst_lsb +: 8]),
        .enable(state.cfg[cfg_nchan_lsb +: 2] >= 2'd2),
        .value(sec2)
    );

    lsm_offset_channel u_ch3
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .primary(primary_abs),
        .offset(state.offsets[24:16]),
        .onoff_hyst(state.cfg[cfg_onoff_hyst_lsb +: 8]),
        .enable(state.cfg[cfg_nchan_lsb +: 2] >= 2'd3),
        .value(sec3)
    );

    lsm_band u_band
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .setpoint(state.setpoint),
        .hyst_pct(state.cfg[cfg_hyst_pct_lsb +: 8]),
        .upper(upper)
    );

    // secondary dimmers listen on the primary dimming address, nothing to drive here
    assign ch1_dim = state.ch1_dim;
    assign active_setpoint = state.setpoint;
    assign band_upper = upper;
    assign ch1_abs = state.ch1_abs;
    assign ch2_abs = state.ch2_abs;
    assign ch3_abs = state.ch3_abs;
    assign shift_busy = state.busy;
    assign hrdata = state.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule
`default_nettype wire

// file: test/lsm_lamp_model.sv
// dimmer actuators and room brightness seen by the sensor
`timescale 1ns/1ps
`default_nettype none
module lsm_lamp_model
    import lsm_pkg::*;
#(
    parameter int unsigned step = 5
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // shared dimming telegram
    input wire lsm_dim_type ch1_dim,
    // daylight jump
    input wire logic set_valid,
    input wire logic [15:0] set_level,
    // measured brightness
    output logic [15:0] brightness
);
    // all actuators share the primary dimming address, so one ramp stands for every channel
    logic moving;
    logic up;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            moving <= 1'b0;
            up <= 1'b0;
            brightness <= 16'h0000;
        end
        else if (set_valid)
            brightness <= set_level;
        else
        begin
            if (ch1_dim.valid)
            begin
                moving <= ch1_dim.code[2:0] != 3'h0;
                up <= ch1_dim.code[3];
            end
            if (moving && up)
                brightness <= brightness + 16'(step);
            else if (moving && brightness >= 16'(step))
                brightness <= brightness - 16'(step);
        end
endmodule
`default_nettype wire

// file: test/lsm_properties.sv
// concurrent checks on the ports of the light setpoint manager
`timescale 1ns/1ps
`default_nettype none
module lsm_properties
    import lsm_pkg::*;
#(
    parameter int unsigned settle_count = 20,
    parameter int unsigned timeout_count = 100
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // telegrams in
    input wire logic in_control,
    input wire logic config_download,
    input wire lsm_dim_type shift_dim,
    input wire logic teach_valid,
    input wire logic sp_reset_valid,
    input wire logic preset_valid,
    input wire logic [15:0] preset_value,
    input wire logic [7:0] primary_abs,
    // telegrams out
    input wire lsm_dim_type ch1_dim,
    input wire logic [15:0] active_setpoint,
    input wire logic [15:0] band_upper,
    input wire logic [7:0] ch1_abs,
    input wire logic [7:0] ch2_abs,
    input wire logic [7:0] ch3_abs,
    input wire logic shift_busy
);
    // cycles since any dimming telegram; a hung shift shows as a long quiet busy spell
    logic [31:0] quiet;
    logic [31:0] next_quiet;
    always_comb
        next_quiet = (shift_dim.valid || ch1_dim.valid) ? 32'h0 : quiet + 32'h1;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            quiet <= 32'h0;
        else
            quiet <= next_quiet;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_dim_forward: assert property (shift_dim.valid && in_control && shift_dim.code[2:0] != 3'h0
        |=> ch1_dim.valid && ch1_dim.code == $past(shift_dim.code)) else $error("dim not forwarded");
    a_stop_forward: assert property (shift_busy && shift_dim.valid && shift_dim.code[2:0] == 3'h0
        |=> ch1_dim.valid && ch1_dim.code[2:0] == 3'h0) else $error("stop not forwarded");
    a_idle_quiet: assert property (!shift_busy && !in_control |=> !ch1_dim.valid)
        else $error("dimming out of control phase");
    a_busy_bounded: assert property (shift_busy |-> quiet <= timeout_count + 3)
        else $error("shift never timed out");
    a_reset_default: assert property (sp_reset_valid && !config_download
        |=> active_setpoint == default_sp_reset) else $error("reset missed default");
    a_preset_take: assert property (preset_valid && !config_download && !sp_reset_valid
        && !teach_valid |=> active_setpoint == $past(preset_value)) else $error("preset missed");
    a_band_above: assert property ($stable(active_setpoint)[*3] |-> band_upper >= active_setpoint)
        else $error("band below setpoint");
    a_ch1_follow: assert property (hresetn |=> ch1_abs == $past(primary_abs))
        else $error("primary output lost");
    a_zero_forces: assert property ($past(primary_abs, 2) == 8'h00
        |-> ch2_abs == 8'h00 && ch3_abs == 8'h00) else $error("secondary on at zero");
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    c_stop: cover property (shift_busy ##1 ch1_dim.valid && ch1_dim.code[2:0] == 3'h0);
    c_reset: cover property (sp_reset_valid);
    c_settled: cover property ($fell(shift_busy));
endmodule
bind lsm_top lsm_properties #(.settle_count(settle_count), .timeout_count(timeout_count)) u_props
(
    .hclk, .hresetn, .hreadyout, .hresp, .in_control, .config_download, .shift_dim, .teach_valid,
    .sp_reset_valid, .preset_valid, .preset_value, .primary_abs, .ch1_dim, .active_setpoint,
    .band_upper, .ch1_abs, .ch2_abs, .ch3_abs, .shift_busy
);
`default_nettype wire

// file: test/lsm_top_tb_top.sv
// self-checking testbench of the light setpoint manager
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %0d seen %0d", nm, e, g); end end
module lsm_top_tb_top;
    import lsm_pkg::*;
    localparam int tn = 100;
    int errors = 0, num_checks = 0, seed = 90217, exp_sp, on2 = 0, on3 = 0, p, st, e2, e3;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, shift_busy;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic in_control = 1'b0, phase_end = 1'b0, config_download = 1'b0, teach_valid = 1'b0;
    logic teach_value = 1'b0, sp_reset_valid = 1'b0, preset_valid = 1'b0, set_valid = 1'b0;
    logic [15:0] preset_value = 16'h0, set_level = 16'h0, brightness, active_setpoint, band_upper;
    logic [7:0] primary_abs = 8'h0, ch1_abs, ch2_abs, ch3_abs;
    lsm_dim_type shift_dim = '0, ch1_dim;
    logic [7:0] ra[7] = '{reg_cfg, reg_default_sp, reg_limits, reg_offsets, reg_status,
        reg_setpoint, 8'h20};
    logic [31:0] re[7] = '{cfg_reset, 32'h190, limits_reset, offsets_reset, 32'h0, 32'h190, 32'h0};
    int ec[8] = '{0, 1, 50, 60, 71, 70, 50, 255};
    always #5 hclk = ~hclk;
    lsm_top #(.settle_count(20), .timeout_count(tn)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .in_control, .phase_end, .brightness, .config_download, .shift_dim, .teach_valid,
        .teach_value, .sp_reset_valid, .preset_valid, .preset_value, .primary_abs, .ch1_dim,
        .active_setpoint, .band_upper, .ch1_abs, .ch2_abs, .ch3_abs, .shift_busy);
    lsm_lamp_model lamp (.hclk, .hresetn, .ch1_dim, .set_valid, .set_level, .brightness);
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic hang();
        errors++;
        end_sim();
    endtask
    task automatic rdy();
        int n;
        for (n = 0; n < 9; n++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                break;
        end
        if (n >= 9)
            hang();
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask
    // one task for every telegram kind keeps pulses exactly one cycle wide
    task automatic tg(input int k, input logic [15:0] v);
        case (k)
            0: teach_valid <= 1'b1;
            1: sp_reset_valid <= 1'b1;
            2: preset_valid <= 1'b1;
            3: config_download <= 1'b1;
            4: phase_end <= 1'b1;
            5: set_valid <= 1'b1;
            default: shift_dim <= '{valid: 1'b1, code: v[3:0]};
        endcase
        teach_value <= v[0];
        preset_value <= v;
        set_level <= v;
        @(posedge hclk);
        {teach_valid, sp_reset_valid, preset_valid, config_download, phase_end, set_valid} <= '0;
        shift_dim <= '0;
        @(posedge hclk);
    endtask
    task automatic csp();
        `chk("setpoint", exp_sp, active_setpoint)
    endtask
    task automatic idle();
        int n;
        st = -1;
        for (n = 0; n < 400; n++)
        begin
            @(posedge hclk);
            if (ch1_dim.valid === 1'b1 && ch1_dim.code[2:0] === 3'h0 && st < 0)
                st = n;
            if (shift_busy !== 1'b1)
                break;
        end
        if (n >= 400)
            hang();
        repeat (2) @(posedge hclk);
        exp_sp = brightness;
    endtask
    function automatic int drv(int p, int o, inout int on);
        if (p == 0 || (o < 0 && p <= -o))
            on = 0;
        else if (o >= 0 || p > 20 - o)
            on = 1;
        return on ? ((p + o > 255) ? 255 : ((p + o < 0) ? 0 : p + o)) : 0;
    endfunction
    initial
    begin
        exp_sp = default_sp_reset;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, ra[i], 32'h0);
            `chk("register", re[i], rd)
        end
        bus(1'b1, reg_setpoint, 32'h1234);
        tg(3, 0);
        csp();
        in_control <= 1'b1;
        tg(5, 16'd500);
        tg(6, 16'h9);
        `chk("dim", 5'h19, ch1_dim)
        repeat (4) @(posedge hclk);
        tg(6, 16'h8);
        `chk("stop", 5'h18, ch1_dim)
        idle();
        csp();
        tg(4, 0);
        exp_sp = default_sp_reset;
        csp();
        in_control <= 1'b0;
        tg(6, 16'h9);
        `chk("dim valid", 1'b0, ch1_dim.valid)
        `chk("busy", 1'b0, shift_busy)
        bus(1'b1, reg_cfg, 32'h1411);
        in_control <= 1'b1;
        tg(5, 16'd1000);
        tg(6, 16'h1);
        idle();
        `chk("timeout stop", 1'b1, st >= tn - 4 && st <= tn + 4)
        csp();
        tg(4, 0);
        csp();
        bus(1'b1, reg_limits, {16'd700, 16'd100});
        tg(5, 16'd600);
        tg(6, 16'h9);
        idle();
        exp_sp = 700;
        csp();
        `chk("limit stop", 1'b1, st >= 0)
        in_control <= 1'b0;
        for (int m = 0; m < 3; m++)
        begin
            bus(1'b1, reg_cfg, 32'h1411 | (m << 1));
            tg(5, 16'(300 + m));
            tg(0, {15'h0, m != 1});
            exp_sp = 300 + m;
            csp();
            tg(5, 16'd222);
            tg(0, {15'h0, m == 1});
            exp_sp = (m == 2) ? 222 : default_sp_reset;
            csp();
        end
        tg(2, 16'd1234);
        exp_sp = 1234;
        csp();
        repeat (3) @(posedge hclk);
        `chk("band", 16'd1480, band_upper)
        tg(1, 0);
        exp_sp = default_sp_reset;
        csp();
        tg(2, 16'd900);
        tg(3, 0);
        exp_sp = 900;
        csp();
        bus(1'b1, reg_cfg, 32'h1419);
        tg(3, 0);
        exp_sp = default_sp_reset;
        csp();
        bus(1'b1, reg_offsets, 32'h0064_01ce);
        bus(1'b1, reg_cfg, 32'h0014_1431);
        for (int i = 0; i < 48; i++)
        begin
            p = (i < 8) ? ec[i] : ($random(seed) & 255);
            primary_abs <= 8'(p);
            repeat (3) @(posedge hclk);
            e2 = drv(p, -50, on2);
            e3 = drv(p, 100, on3);
            `chk("ch1", 8'(p), ch1_abs)
            `chk("ch2", 8'(e2), ch2_abs)
            `chk("ch3", 8'(e3), ch3_abs)
        end
        bus(1'b1, reg_cfg, 32'h0014_1421);
        primary_abs <= 8'd200;
        repeat (3) @(posedge hclk);
        `chk("ch2 two", 8'd150, ch2_abs)
        `chk("ch3 off", 8'h00, ch3_abs)
        end_sim();
    end
endmodule
`default_nettype wire
